// ==== light_alarm_pkg.sv ====
// Constants shared by the light sensor front end and its converter core.
// Assumes an 8-bit register port and a separate oscillator clock domain.
package light_alarm_pkg;
   // Register offsets
   localparam logic [2:0] OFS_SETUP = 3'h0;
   localparam logic [2:0] OFS_CTRL = 3'h1;
   localparam logic [2:0] OFS_THR_HI = 3'h2;
   localparam logic [2:0] OFS_THR_LO = 3'h3;
   localparam logic [2:0] OFS_LIGHT_LO = 3'h4;
   localparam logic [2:0] OFS_LIGHT_HI = 3'h5;
   localparam logic [2:0] OFS_CYC_LO = 3'h6;
   localparam logic [2:0] OFS_CYC_HI = 3'h7;
   // Address bits that carry write-only commands
   localparam int ADR_SYNC = 7;
   localparam int ADR_CLEAR = 6;
   // Setup register fields
   localparam int SETUP_RUN = 7;
   localparam int SETUP_PD = 6;
   localparam int SETUP_EXT = 5;
   localparam logic [7:0] SETUP_MASK = 8'hef;
   // Control register fields
   localparam int CTRL_FLAG = 5;
   localparam logic [7:0] CTRL_MASK = 8'h0f;
   // Reset values and the fixed threshold low byte
   localparam logic [7:0] SETUP_RST = 8'h00;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] THR_HI_RST = 8'hff;
   localparam logic [7:0] THR_LO_RST = 8'h00;
   localparam logic [7:0] THR_LOW_BYTE = 8'h00;
   // Diode select codes
   localparam logic [1:0] DIODE_LIGHT = 2'h2;
   // Last cycle index per conversion length code
   localparam logic [15:0] LAST_65536 = 16'hffff;
   localparam logic [15:0] LAST_4096 = 16'h0fff;
   localparam logic [15:0] LAST_256 = 16'h00ff;
   localparam logic [15:0] LAST_16 = 16'h000f;
   // Range constants
   localparam logic [16:0] RANGE_K1 = 17'd2000;
   localparam logic [16:0] RANGE_K2 = 17'd8000;
   localparam logic [16:0] RANGE_K3 = 17'd32000;
   localparam logic [16:0] RANGE_K4 = 17'd128000;
   // Persistence counts
   localparam logic [4:0] PERSIST_1 = 5'h01;
   localparam logic [4:0] PERSIST_4 = 5'h04;
   localparam logic [4:0] PERSIST_8 = 5'h08;
   localparam logic [4:0] PERSIST_16 = 5'h10;
   typedef enum logic [1:0] {PH_IDLE, PH_ARRAY1, PH_ARRAY2} ext_phase_t;
endpackage : light_alarm_pkg

// ==== conv_if.sv ====
// Bundle between the register side (clk_sys) and the converter core (clk_osc).
// Configuration and sync travel as levels and toggles; results are held stable.
`timescale 1ns/1ps
interface conv_if;
   logic run;
   logic pd;
   logic ext;
   logic [1:0] diode;
   logic [1:0] len;
   logic sync_tgl;
   logic done_tgl;
   logic [15:0] light;
   logic [15:0] cycles;
   modport ctl (output run, pd, ext, diode, len, sync_tgl, input done_tgl, light, cycles);
   modport conv (input run, pd, ext, diode, len, sync_tgl, output done_tgl, light, cycles);
endinterface : conv_if

// ==== sync3.sv ====
// Three-stage synchroniser; output moves once stages two and three agree.
// Assumes the input is a level held for several destination clocks.
`timescale 1ns/1ps
module sync3 #(
   parameter int W = 1
) (
   // Destination clock and reset
   input wire logic clk,
   input wire logic rst,
   // Data
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         q <= '0;
      end
      else
      begin
         s1_q <= d;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q)
            q <= s3_q;
      end
   end
endmodule : sync3

// ==== conv_core.sv ====
// Converter timing core on the internal oscillator clock.
// Assumes light_raw holds the converter's unsigned result when a conversion ends.
`timescale 1ns/1ps
module conv_core
   import light_alarm_pkg::*;
(
   // Oscillator clock and reset
   input wire logic clk_osc,
   input wire logic rst,
   // Converter result
   input wire logic [15:0] light_raw,
   // Register side
   conv_if.conv cv
);
   function automatic logic [15:0] last_cycle(input logic [1:0] code);
      case (code)
         2'h0: last_cycle = LAST_65536;
         2'h1: last_cycle = LAST_4096;
         2'h2: last_cycle = LAST_256;
         default: last_cycle = LAST_16;
      endcase
   endfunction : last_cycle

   logic [6:0] cfg_s;
   logic sync_s;
   logic sync_seen_q;
   logic [15:0] cyc_q;
   logic [15:0] cyc_d;
   ext_phase_t phase_q;
   ext_phase_t phase_d;
   logic done_q;
   logic capture;
   logic [15:0] light_q;
   logic [15:0] cycles_q;

   sync3 #(.W(7)) u_cfg (.clk(clk_osc), .rst(rst),
      .d({cv.run, cv.pd, cv.ext, cv.diode, cv.len}), .q(cfg_s));
   sync3 #(.W(1)) u_sync (.clk(clk_osc), .rst(rst), .d(cv.sync_tgl), .q(sync_s));

   wire run_s = cfg_s[6];
   wire pd_s = cfg_s[5];
   wire ext_s = cfg_s[4];
   wire [1:0] diode_s = cfg_s[3:2];
   wire [1:0] len_s = cfg_s[1:0];
   // Converter held idle unless enabled, powered and counting light
   wire active = run_s && !pd_s && (diode_s == DIODE_LIGHT);
   wire sync_ev = sync_s ^ sync_seen_q;
   wire int_end = (cyc_q == last_cycle(len_s));

   always_comb
   begin
      cyc_d = cyc_q + 16'h0001;
      phase_d = phase_q;
      capture = 1'b0;
      if (!active)
      begin
         cyc_d = '0;
         phase_d = PH_IDLE;
      end
      else if (ext_s)
      begin
         if (phase_q == PH_IDLE)
            cyc_d = '0;
         if (sync_ev)
         begin
            case (phase_q)
               PH_IDLE: phase_d = PH_ARRAY1;
               PH_ARRAY1: phase_d = PH_ARRAY2;
               PH_ARRAY2:
               begin
                  capture = 1'b1;
                  phase_d = PH_ARRAY1;
                  cyc_d = '0;
               end
               default: phase_d = PH_IDLE;
            endcase
         end
      end
      else if (int_end)
      begin
         capture = 1'b1;
         cyc_d = '0;
      end
   end

   always_ff @(posedge clk_osc or posedge rst)
   begin
      if (rst)
      begin
         sync_seen_q <= 1'b0;
         cyc_q <= '0;
         phase_q <= PH_IDLE;
      end
      else
      begin
         sync_seen_q <= sync_s;
         cyc_q <= cyc_d;
         phase_q <= phase_d;
      end
   end

   // Results stay stable until the next conversion ends
   always_ff @(posedge clk_osc or posedge rst)
   begin
      if (rst)
      begin
         done_q <= 1'b0;
         light_q <= '0;
         cycles_q <= '0;
      end
      else if (capture)
      begin
         done_q <= !done_q;
         light_q <= light_raw;
         cycles_q <= cyc_q + 16'h0001;
      end
   end

   assign cv.done_tgl = done_q;
   assign cv.light = light_q;
   assign cv.cycles = cycles_q;
endmodule : conv_core

// ==== light_sensor_config_and_alarm.sv ====
// Register file, threshold alarm and result capture of the light sensor.
// Assumes a decoded serial-bus register port on clk_sys and an oscillator clock.
// What this block does
// - Diode codes 00/01 disable, 10 converts light, 11 does nothing.
// - Length codes give 65536, 4096, 256 or 16 oscillator cycles.
// - Length sets integration time as well as count resolution.
// - Alarm flag at control bit 5 sets on alarm, else stays zero.
// - Writing zero to control bit 5 clears the alarm flag.
// - Range field selects 2000, 8000, 32000 or 128000.
// - Alarm only after m consecutive out-of-window readings.
// - Persistence codes give m of 1, 4, 8 or 16.
// - Threshold byte is the upper byte; lower byte is zero.
// - Upper threshold resets to ff, lower to 00.
// - Count registers update at the end of every integration.
// - Light count low byte at 04, high byte at 05.
// - Cycle counter increments every oscillator cycle while integrating.
// - Cycle count captured at end, low byte 06, high byte 07.
// - Cycle count is meaningful in externally timed mode only.
// - Setup bit 7 zero holds converter reset; one runs it.
// - Setup bit 5 one makes host syncs bound each integration.
// - Write with address bit 7 ends and restarts integration, external mode.
// - Write with address bit 6 clears the pending alarm.
`timescale 1ns/1ps
module light_sensor_config_and_alarm
   import light_alarm_pkg::*;
(
   // System clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Oscillator clock and converter result
   input wire logic clk_osc,
   input wire logic [15:0] light_raw,
   // Register port
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // Alarm pin, open drain
   input wire logic alarm_n_i,
   output logic alarm_n_o,
   output logic alarm_n_oe,
   // Decoded settings
   output logic [16:0] range_value,
   output logic osc_fast
);
   function automatic logic [4:0] persist_count(input logic [1:0] code);
      case (code)
         2'h0: persist_count = PERSIST_1;
         2'h1: persist_count = PERSIST_4;
         2'h2: persist_count = PERSIST_8;
         default: persist_count = PERSIST_16;
      endcase
   endfunction : persist_count

   function automatic logic [16:0] range_of(input logic [1:0] code);
      case (code)
         2'h0: range_of = RANGE_K1;
         2'h1: range_of = RANGE_K2;
         2'h2: range_of = RANGE_K3;
         default: range_of = RANGE_K4;
      endcase
   endfunction : range_of

   conv_if cv ();

   logic [7:0] setup_q;
   logic [3:0] ctrl_q;
   logic flag_q;
   logic [7:0] thr_hi_q;
   logic [7:0] thr_lo_q;
   logic [15:0] light_q;
   logic [15:0] cycles_q;
   logic [4:0] miss_q;
   logic [4:0] miss_d;
   logic sync_tgl_q;
   logic done_s;
   logic done_seen_q;
   logic [7:0] rdata_q;
   logic [7:0] rd_mux;

   conv_core u_core (.clk_osc(clk_osc), .rst(rst), .light_raw(light_raw), .cv(cv));
   sync3 #(.W(1)) u_done (.clk(clk_sys), .rst(rst), .d(cv.done_tgl), .q(done_s));

   // Write decode
   wire cmd_wr = reg_wr && !reg_addr[ADR_SYNC] && !reg_addr[ADR_CLEAR];
   wire wr_setup = cmd_wr && (reg_addr[2:0] == OFS_SETUP);
   wire wr_ctrl = cmd_wr && (reg_addr[2:0] == OFS_CTRL);
   wire wr_thr_hi = cmd_wr && (reg_addr[2:0] == OFS_THR_HI);
   wire wr_thr_lo = cmd_wr && (reg_addr[2:0] == OFS_THR_LO);
   wire ext_mode = setup_q[SETUP_EXT];
   wire sync_cmd = reg_wr && reg_addr[ADR_SYNC] && ext_mode;
   wire clear_cmd = (reg_wr && reg_addr[ADR_CLEAR])
      || (wr_ctrl && !reg_wdata[CTRL_FLAG]);

   // Result arrival and window test
   wire res_evt = done_s ^ done_seen_q;
   wire [15:0] thr_hi_full = {thr_hi_q, THR_LOW_BYTE};
   wire [15:0] thr_lo_full = {thr_lo_q, THR_LOW_BYTE};
   wire out_win = (cv.light > thr_hi_full) || (cv.light < thr_lo_full);
   wire [4:0] persist_m = persist_count(ctrl_q[1:0]);
   wire [4:0] miss_inc = (miss_q == PERSIST_16) ? miss_q : miss_q + 5'h01;
   wire alarm_set = res_evt && out_win && (miss_inc >= persist_m);

   always_comb
   begin
      miss_d = miss_q;
      if (res_evt)
         miss_d = out_win ? miss_inc : 5'h00;
   end

   // Read selection
   always_comb
   begin
      case (reg_addr[2:0])
         OFS_SETUP: rd_mux = setup_q;
         OFS_CTRL: rd_mux = {2'h0, flag_q, 1'b0, ctrl_q};
         OFS_THR_HI: rd_mux = thr_hi_q;
         OFS_THR_LO: rd_mux = thr_lo_q;
         OFS_LIGHT_LO: rd_mux = light_q[7:0];
         OFS_LIGHT_HI: rd_mux = light_q[15:8];
         OFS_CYC_LO: rd_mux = cycles_q[7:0];
         OFS_CYC_HI: rd_mux = cycles_q[15:8];
         default: rd_mux = 8'h00;
      endcase
   end

   // Configuration registers
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         setup_q <= SETUP_RST;
         ctrl_q <= CTRL_RST[3:0];
         thr_hi_q <= THR_HI_RST;
         thr_lo_q <= THR_LO_RST;
      end
      else
      begin
         if (wr_setup)
            setup_q <= reg_wdata & SETUP_MASK;
         if (wr_ctrl)
            ctrl_q <= reg_wdata[3:0] & CTRL_MASK[3:0];
         if (wr_thr_hi)
            thr_hi_q <= reg_wdata;
         if (wr_thr_lo)
            thr_lo_q <= reg_wdata;
      end
   end

   // Alarm flag; a new alarm wins over a clear in the same cycle
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         flag_q <= 1'b0;
      else if (alarm_set)
         flag_q <= 1'b1;
      else if (clear_cmd)
         flag_q <= 1'b0;
   end

   // Result capture and persistence
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         done_seen_q <= 1'b0;
         miss_q <= '0;
         light_q <= '0;
         cycles_q <= '0;
      end
      else
      begin
         done_seen_q <= done_s;
         miss_q <= miss_d;
         if (res_evt)
         begin
            light_q <= cv.light;
            cycles_q <= cv.cycles;
         end
      end
   end

   // Sync command toggle and read data
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         sync_tgl_q <= 1'b0;
         rdata_q <= '0;
      end
      else
      begin
         if (sync_cmd)
            sync_tgl_q <= !sync_tgl_q;
         if (reg_rd)
            rdata_q <= rd_mux;
      end
   end

   assign cv.run = setup_q[SETUP_RUN];
   assign cv.pd = setup_q[SETUP_PD];
   assign cv.ext = ext_mode;
   assign cv.diode = setup_q[3:2];
   assign cv.len = setup_q[1:0];
   assign cv.sync_tgl = sync_tgl_q;
   assign reg_rdata = rdata_q;
   assign alarm_n_o = 1'b0;
   assign alarm_n_oe = flag_q;
   assign range_value = range_of(ctrl_q[3:2]);
   assign osc_fast = ctrl_q[3];

   a_flag_needs_miss: assert property (@(posedge clk_sys) disable iff (rst)
      $rose(flag_q) |-> $past(res_evt) && $past(out_win) && ($past(miss_inc) >= $past(persist_m)))
      else $error("Alarm flag rose without enough out-of-window readings");

   a_flag_sets_on: assert property (@(posedge clk_sys) disable iff (rst)
      res_evt && out_win && (miss_inc >= persist_m) |=> flag_q)
      else $error("Alarm flag missed a persistent out-of-window reading");

   a_flag_ctrl_clr: assert property (@(posedge clk_sys) disable iff (rst)
      wr_ctrl && !reg_wdata[CTRL_FLAG] && !alarm_set |=> !flag_q)
      else $error("Writing zero to the flag did not clear it");

   a_flag_addr_clr: assert property (@(posedge clk_sys) disable iff (rst)
      reg_wr && reg_addr[ADR_CLEAR] && !alarm_set |=> !flag_q)
      else $error("Clear command did not clear the alarm");

   a_pin_tracks_flag: assert property (@(posedge clk_sys) disable iff (rst)
      $rose(flag_q) |-> alarm_n_oe && !alarm_n_o ##1 (alarm_n_oe || !flag_q))
      else $error("Alarm pin not driven low while flag set");

   a_miss_in_window: assert property (@(posedge clk_sys) disable iff (rst)
      res_evt && !out_win |=> miss_q == 5'h00)
      else $error("Miss counter not cleared by in-window reading");

   a_count_update: assert property (@(posedge clk_sys) disable iff (rst)
      res_evt |=> (light_q == $past(cv.light)) && (cycles_q == $past(cv.cycles)))
      else $error("Result registers not updated at end of integration");

   a_sync_gated: assert property (@(posedge clk_sys) disable iff (rst)
      reg_wr && reg_addr[ADR_SYNC] && !ext_mode |=> $stable(sync_tgl_q))
      else $error("Sync command acted outside externally timed mode");

   a_persist_map: assert property (@(posedge clk_sys) disable iff (rst)
      (ctrl_q[1:0] == 2'h3) |-> persist_m == PERSIST_16)
      else $error("Persistence code three does not give sixteen");

   a_range_map: assert property (@(posedge clk_sys) disable iff (rst)
      (ctrl_q[3:2] == 2'h0) |-> range_value == RANGE_K1)
      else $error("Range code zero does not give the first constant");

   a_range_code1: assert property (@(posedge clk_sys) disable iff (rst)
      (ctrl_q[3:2] == 2'h1) |-> range_value == RANGE_K2)
      else $error("Range code one does not give the second constant");

   a_range_code2: assert property (@(posedge clk_sys) disable iff (rst)
      (ctrl_q[3:2] == 2'h2) |-> range_value == RANGE_K3)
      else $error("Range code two does not give the third constant");

   a_range_code3: assert property (@(posedge clk_sys) disable iff (rst)
      (ctrl_q[3:2] == 2'h3) |-> range_value == RANGE_K4)
      else $error("Range code three does not give the fourth constant");

   a_persist_code0: assert property (@(posedge clk_sys) disable iff (rst)
      (ctrl_q[1:0] == 2'h0) |-> persist_m == PERSIST_1)
      else $error("Persistence code zero does not give one");

   a_persist_code1: assert property (@(posedge clk_sys) disable iff (rst)
      (ctrl_q[1:0] == 2'h1) |-> persist_m == PERSIST_4)
      else $error("Persistence code one does not give four");

   a_persist_code2: assert property (@(posedge clk_sys) disable iff (rst)
      (ctrl_q[1:0] == 2'h2) |-> persist_m == PERSIST_8)
      else $error("Persistence code two does not give eight");

   a_thr_hi_write: assert property (@(posedge clk_sys) disable iff (rst)
      wr_thr_hi |=> thr_hi_q == $past(reg_wdata))
      else $error("Upper threshold write did not land");

   a_thr_lo_write: assert property (@(posedge clk_sys) disable iff (rst)
      wr_thr_lo |=> thr_lo_q == $past(reg_wdata))
      else $error("Lower threshold write did not land");

   a_ctrl_write: assert property (@(posedge clk_sys) disable iff (rst)
      wr_ctrl |=> ctrl_q == $past(reg_wdata[3:0]))
      else $error("Control field write did not land");

   a_light_lo_read: assert property (@(posedge clk_sys) disable iff (rst)
      reg_rd && (reg_addr[2:0] == OFS_LIGHT_LO) |=> reg_rdata == $past(light_q[7:0]))
      else $error("Light count low byte read wrong");

   a_light_hi_read: assert property (@(posedge clk_sys) disable iff (rst)
      reg_rd && (reg_addr[2:0] == OFS_LIGHT_HI) |=> reg_rdata == $past(light_q[15:8]))
      else $error("Light count high byte read wrong");

   a_cyc_lo_read: assert property (@(posedge clk_sys) disable iff (rst)
      reg_rd && (reg_addr[2:0] == OFS_CYC_LO) |=> reg_rdata == $past(cycles_q[7:0]))
      else $error("Cycle count low byte read wrong");

   a_cyc_hi_read: assert property (@(posedge clk_sys) disable iff (rst)
      reg_rd && (reg_addr[2:0] == OFS_CYC_HI) |=> reg_rdata == $past(cycles_q[15:8]))
      else $error("Cycle count high byte read wrong");

   a_ctrl_read_flag: assert property (@(posedge clk_sys) disable iff (rst)
      reg_rd && (reg_addr[2:0] == OFS_CTRL) |=> reg_rdata[CTRL_FLAG] == $past(flag_q))
      else $error("Control read does not show the alarm flag");

   a_flag_holds: assert property (@(posedge clk_sys) disable iff (rst)
      flag_q && !clear_cmd |=> flag_q)
      else $error("Alarm flag dropped without a clear");

   a_flag_stays_low: assert property (@(posedge clk_sys) disable iff (rst)
      !flag_q && !alarm_set |=> !flag_q)
      else $error("Alarm flag rose without an alarm");

   a_pin_release: assert property (@(posedge clk_sys) disable iff (rst)
      !flag_q |-> !alarm_n_oe)
      else $error("Alarm pin driven while flag clear");

   a_pin_low_level: assert property (@(posedge clk_sys) disable iff (rst)
      alarm_n_oe |-> !alarm_n_o)
      else $error("Alarm pin driven high");

   a_sync_toggles: assert property (@(posedge clk_sys) disable iff (rst)
      sync_cmd |=> sync_tgl_q != $past(sync_tgl_q))
      else $error("Sync command not passed to the converter");

   a_miss_counts: assert property (@(posedge clk_sys) disable iff (rst)
      res_evt && out_win && (miss_q < PERSIST_16) |=> miss_q == $past(miss_q) + 5'h01)
      else $error("Miss counter did not count an out-of-window reading");

   c_alarm_raised: cover property (@(posedge clk_sys) disable iff (rst) $rose(flag_q));
   c_alarm_cleared: cover property (@(posedge clk_sys) disable iff (rst) $fell(flag_q));
   c_sync_sent: cover property (@(posedge clk_sys) disable iff (rst) sync_cmd);
   c_result_seen: cover property (@(posedge clk_sys) disable iff (rst) res_evt ##[1:100] res_evt);
endmodule : light_sensor_config_and_alarm

// ==== host_model.sv ====
// Host side model: serial bus master reduced to register write/read cycles.
// Assumes the decoded register port of the light sensor front end on clk_sys.
`timescale 1ns/1ps
module host_model (
   // Clock
   input wire logic clk_sys,
   // Register port
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata
);
   initial
   begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end

   // One write pulse; address bits 7 and 6 carry sync and alarm clear
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~v;
   endtask : wr

   // Read data is taken one edge after the strobe is accepted
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      @(posedge clk_sys);
      v = reg_rdata;
   endtask : rd
endmodule : host_model

// ==== light_sensor_config_and_alarm_tb.sv ====
// Self-checking bench of the light sensor front end.
// Assumes host_model as bus master and a free-running 30 ns oscillator.
`timescale 1ns/1ps
module light_sensor_config_and_alarm_tb;
   import light_alarm_pkg::*;
   logic clk_sys, clk_osc, rst;
   logic [15:0] light_raw, light_next, seed;
   logic reg_wr, reg_rd;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, d, d2;
   logic alarm_n_i, alarm_n_o, alarm_n_oe, osc_fast;
   logic [16:0] range_value;
   int n_fail, tests_run;
   logic [7:0] rst_val [4] = '{8'h00, 8'h00, 8'hff, 8'h00};
   logic [16:0] rng [4] = '{17'd2000, 17'd8000, 17'd32000, 17'd128000};
   int pm [4] = '{1, 4, 8, 16};
   logic [7:0] off_setup [5] = '{8'h0b, 8'h83, 8'h87, 8'h8f, 8'hcb};

   // Open-drain pin with pull-up
   assign alarm_n_i = alarm_n_oe ? alarm_n_o : 1'b1;

   initial
   begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   initial
   begin
      clk_osc = 1'b0;
      #7;
      forever #15 clk_osc = ~clk_osc;
   end

   always @(posedge clk_osc) light_raw <= light_next;

   light_sensor_config_and_alarm i_light_sensor_config_and_alarm (
      .clk_sys(clk_sys), .rst(rst), .clk_osc(clk_osc), .light_raw(light_raw),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .alarm_n_i(alarm_n_i), .alarm_n_o(alarm_n_o),
      .alarm_n_oe(alarm_n_oe), .range_value(range_value), .osc_fast(osc_fast)
   );

   host_model i_host_model (
      .clk_sys(clk_sys), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata)
   );

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : wait_cyc

   task automatic end_of_test;
      if (n_fail == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : end_of_test

   initial
   begin
      #200000;
      n_fail++;
      end_of_test();
   end

   initial
   begin
      n_fail = 0;
      tests_run = 0;
      rst = 1'b1;
      seed = 16'd21253;
      light_next = 16'h0000;
      light_raw = 16'h0000;
      repeat (20) @(posedge clk_sys);
      rst <= 1'b0;
      wait_cyc(1);
      chk(range_value, 17'd2000);
      chk(alarm_n_oe, 1'b0);
      for (int a = 0; a < 4; a++)
      begin
         i_host_model.rd(8'(a), d);
         chk(d, rst_val[a]);
      end
      // Range field decode and readback
      for (int k = 0; k < 4; k++)
      begin
         i_host_model.wr(8'h01, 8'(k << 2));
         wait_cyc(1);
         chk(range_value, rng[k]);
         chk(osc_fast, k[1]);
         i_host_model.rd(8'h01, d);
         chk(d, 8'(k << 2));
      end
      // Random thresholds
      for (int i = 0; i < 4; i++)
      begin
         seed = lfsr(seed);
         i_host_model.wr(8'h02, seed[7:0]);
         i_host_model.wr(8'h03, seed[15:8]);
         i_host_model.rd(8'h02, d);
         chk(d, seed[7:0]);
         i_host_model.rd(8'h03, d);
         chk(d, seed[15:8]);
      end
      // Internal timing, 16 cycles per conversion
      i_host_model.wr(8'h00, 8'h8b);
      for (int i = 0; i < 3; i++)
      begin
         seed = lfsr(seed);
         light_next = seed;
         wait_cyc(60);
         i_host_model.wr(8'h04, ~seed[7:0]);
         i_host_model.wr(8'h80, 8'h00);
         i_host_model.rd(8'h04, d);
         i_host_model.rd(8'h05, d2);
         chk({d2, d}, seed);
      end
      // Disabled, idle or powered-down settings freeze the result
      foreach (off_setup[j])
      begin
         i_host_model.wr(8'h00, off_setup[j]);
         wait_cyc(20);
         light_next = ~seed;
         wait_cyc(60);
         i_host_model.rd(8'h04, d);
         i_host_model.rd(8'h05, d2);
         chk({d2, d}, seed);
         light_next = seed;
      end
      // Persistence, window 2000..4000 inclusive, both sides
      i_host_model.wr(8'h02, 8'h40);
      i_host_model.wr(8'h03, 8'h20);
      i_host_model.wr(8'h00, 8'h8b);
      for (int c = 0; c < 4; c++)
      begin
         light_next = 16'h4000;
         wait_cyc(60);
         i_host_model.wr(8'h01, 8'(c));
         wait_cyc(2);
         chk(alarm_n_oe, 1'b0);
         light_next = c[0] ? 16'h1fff : 16'h4001;
         if (pm[c] > 1)
         begin
            wait_cyc(pm[c] * 24 - 34);
            chk(alarm_n_oe, 1'b0);
         end
         wait_cyc(68);
         chk(alarm_n_oe, 1'b1);
         chk(alarm_n_i, 1'b0);
         i_host_model.rd(8'h01, d);
         chk(d, 8'h20 | 8'(c));
      end
      light_next = 16'h3000;
      wait_cyc(60);
      i_host_model.wr(8'h40, 8'h00);
      wait_cyc(2);
      chk(alarm_n_oe, 1'b0);
      // External timing, syncs 120 cycles apart
      i_host_model.wr(8'h00, 8'hab);
      seed = lfsr(seed);
      light_next = seed;
      wait_cyc(20);
      for (int s = 0; s < 3; s++)
      begin
         i_host_model.wr(8'h80, 8'h00);
         wait_cyc(118);
      end
      i_host_model.rd(8'h06, d);
      i_host_model.rd(8'h07, d2);
      chk(({d2, d} >= 16'd157) && ({d2, d} <= 16'd163), 1'b1);
      i_host_model.rd(8'h04, d);
      i_host_model.rd(8'h05, d2);
      chk({d2, d}, seed);
      end_of_test();
   end
endmodule : light_sensor_config_and_alarm_tb
